// ==== shared/dma_chan_cfg.svh ====
// How it works
// - Enable bit 1 lets a finished transfer raise the interrupt; clear blocks it.
// - Enable bit 0 lets a bus error raise the interrupt; clear blocks it.
// - The enable register reads 0x0000_0001 after reset.
// - Status bit 1 sets when the whole transfer ends; writing one clears it.
// - Status bit 0 sets on a bus ERROR response while the channel is busy; writing one clears it.
// - A bus ERROR stops the transfer, flags it and returns the channel to idle.
// - A one-word buffer at 0x80 is read-only and resets to zero.
// - A controller soft reset clears the remaining byte count to zero.
`ifndef DMA_CHAN_CFG_SVH
`define DMA_CHAN_CFG_SVH
`define OFF_CTRL 8'h00
`define OFF_REMAIN 8'h1c
`define OFF_INT_ENABLE 8'h20
`define OFF_INT_STATUS 8'h24
`define OFF_SHARED_BUF 8'h80
`define BIT_SOFT_RESET 0
`define BIT_DONE 1
`define BIT_BUS_ERR 0
`define INT_ENABLE_RESET 2'h1
`define INT_STATUS_RESET 2'h0
`define SHARED_BUF_RESET 32'h0000_0000
`define BEAT_BYTES 16'h0004
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== shared/dma_chan_pkg.sv ====
package dma_chan_pkg;
  typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_REMAIN, SEL_IEN, SEL_ISR, SEL_BUF} reg_sel_t;
  typedef enum {CH_IDLE, CH_BUSY} chan_state_t;
  typedef struct packed {
    logic start;
    logic [15:0] count;
    logic beat;
    logic [31:0] data;
    logic err;
  } xfer_in_t;
  typedef struct packed {
    logic busy;
    logic abort;
  } xfer_out_t;
endpackage : dma_chan_pkg

// ==== hw/dma_chan_irq.sv ====
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "dma_chan_cfg.svh"

module dma_chan_irq (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write address and data.
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Register bus write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Register bus read.
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Transfer engine side.
  input wire dma_chan_pkg::xfer_in_t xfer_in,
  output dma_chan_pkg::xfer_out_t xfer_out,
  // Interrupt.
  output logic irq
);
  import dma_chan_pkg::*;

  function automatic reg_sel_t decode(input logic [7:0] addr);
    case (addr)
      `OFF_CTRL: decode = SEL_CTRL;
      `OFF_REMAIN: decode = SEL_REMAIN;
      `OFF_INT_ENABLE: decode = SEL_IEN;
      `OFF_INT_STATUS: decode = SEL_ISR;
      `OFF_SHARED_BUF: decode = SEL_BUF;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  // Bus slave state.
  logic aw_have_r, aw_have_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic w_have_r, w_have_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  // Channel state.
  chan_state_t state_r, state_nxt;
  logic [15:0] remain_r, remain_nxt;
  logic [31:0] buf_r, buf_nxt;
  logic [1:0] ien_r, ien_nxt;
  logic [1:0] isr_r, isr_nxt;
  logic abort_r, abort_nxt;

  logic wr_go;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic soft_rst;
  logic done_ev;
  logic err_ev;

  assign awready = !aw_have_r && !bvalid_r;
  assign wready = !w_have_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign wr_go = aw_have_r && w_have_r;
  assign wr_sel = decode(aw_addr_r);
  assign rd_sel = decode(araddr);
  assign soft_rst = wr_go && wr_sel == SEL_CTRL && w_strb_r[0] && w_data_r[`BIT_SOFT_RESET];
  // A bus error wins over a beat seen in the same cycle.
  assign err_ev = state_r == CH_BUSY && xfer_in.err;
  assign done_ev = state_r == CH_BUSY && !xfer_in.err && xfer_in.beat
                   && remain_r <= `BEAT_BYTES;
  assign irq = |(isr_r & ien_r);
  assign xfer_out.busy = state_r == CH_BUSY;
  assign xfer_out.abort = abort_r;

  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt = w_have_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (awvalid && awready) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_have_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_go) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `RESP_OKAY;
      case (rd_sel)
        SEL_REMAIN: rdata_nxt = {16'h0000, remain_r};
        SEL_IEN: rdata_nxt = {30'h0, ien_r};
        SEL_ISR: rdata_nxt = {30'h0, isr_r};
        SEL_BUF: rdata_nxt = buf_r;
        SEL_CTRL: rdata_nxt = {31'h0, xfer_out.busy};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    state_nxt = state_r;
    remain_nxt = remain_r;
    buf_nxt = buf_r;
    ien_nxt = ien_r;
    isr_nxt = isr_r;
    abort_nxt = 1'b0;
    if (wr_go && wr_sel == SEL_IEN && w_strb_r[0]) begin
      ien_nxt = w_data_r[1:0];
    end
    if (wr_go && wr_sel == SEL_ISR && w_strb_r[0]) begin
      isr_nxt = isr_r & ~w_data_r[1:0];
    end
    // Hardware set wins over a same-cycle clear.
    isr_nxt[`BIT_DONE] = isr_nxt[`BIT_DONE] | done_ev;
    isr_nxt[`BIT_BUS_ERR] = isr_nxt[`BIT_BUS_ERR] | err_ev;
    case (state_r)
      CH_IDLE: begin
        if (xfer_in.start && xfer_in.count != 16'h0000) begin
          state_nxt = CH_BUSY;
          remain_nxt = xfer_in.count;
        end
      end
      CH_BUSY: begin
        if (xfer_in.err) begin
          state_nxt = CH_IDLE;
          abort_nxt = 1'b1;
        end else if (xfer_in.beat) begin
          buf_nxt = xfer_in.data;
          remain_nxt = done_ev ? 16'h0000 : remain_r - `BEAT_BYTES;
          if (done_ev) begin
            state_nxt = CH_IDLE;
          end
        end
      end
      default: state_nxt = CH_IDLE;
    endcase
    if (soft_rst) begin
      state_nxt = CH_IDLE;
      remain_nxt = 16'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r <= w_have_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= CH_IDLE;
      remain_r <= 16'h0000;
      buf_r <= `SHARED_BUF_RESET;
      ien_r <= `INT_ENABLE_RESET;
      isr_r <= `INT_STATUS_RESET;
      abort_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      remain_r <= remain_nxt;
      buf_r <= buf_nxt;
      ien_r <= ien_nxt;
      isr_r <= isr_nxt;
      abort_r <= abort_nxt;
    end
  end

  // Checks.
  logic past_rst_r;
  always_ff @(posedge aclk) begin
    past_rst_r <= !aresetn;
  end

  sequence s_busy_err;
    state_r == CH_BUSY && xfer_in.err;
  endsequence

  sequence s_stopped;
    state_r == CH_IDLE && abort_r && isr_r[`BIT_BUS_ERR];
  endsequence

  property p_done_irq;
    @(posedge aclk) disable iff (!aresetn)
      done_ev && ien_r[`BIT_DONE] && !(wr_go && wr_sel == SEL_IEN) |=> irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done did not raise irq");

  property p_err_gate;
    @(posedge aclk) disable iff (!aresetn)
      !ien_r[`BIT_BUS_ERR] && !(isr_r[`BIT_DONE] && ien_r[`BIT_DONE]) |-> !irq;
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("irq without enabled flag");

  property p_reset_val;
    @(posedge aclk) disable iff (!aresetn)
      past_rst_r |-> ien_r == `INT_ENABLE_RESET && isr_r == 2'h0;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad enable reset value");

  property p_done_flag;
    @(posedge aclk) disable iff (!aresetn)
      done_ev |=> isr_r[`BIT_DONE] && state_r == CH_IDLE && remain_r == 16'h0000;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag not set");

  property p_done_clear;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && wr_sel == SEL_ISR && w_strb_r[0] && w_data_r[`BIT_DONE] && !done_ev
      |=> !isr_r[`BIT_DONE];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

  property p_err_flag;
    @(posedge aclk) disable iff (!aresetn)
      err_ev |=> isr_r[`BIT_BUS_ERR] ##1 isr_r[`BIT_BUS_ERR] || $past(wr_go);
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not set");

  property p_err_stop;
    @(posedge aclk) disable iff (!aresetn)
      s_busy_err |=> s_stopped ##1 !abort_r;
  endproperty
  a_err_stop: assert property (p_err_stop) else $error("error did not stop channel");

  property p_buf_ro;
    @(posedge aclk) disable iff (!aresetn)
      !(state_r == CH_BUSY && xfer_in.beat) |=> $stable(buf_r);
  endproperty
  a_buf_ro: assert property (p_buf_ro) else $error("buffer changed without beat");

  property p_soft_rst;
    @(posedge aclk) disable iff (!aresetn)
      soft_rst |=> remain_r == 16'h0000 && state_r == CH_IDLE;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset kept count");

  property p_irq_cause;
    @(posedge aclk) disable iff (!aresetn)
      irq |-> (isr_r[0] && ien_r[0]) || (isr_r[1] && ien_r[1]);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule : dma_chan_irq

// ==== bench/bus_slave_model.sv ====
`timescale 1ns/100ps
module bus_slave_model (
  // Clock.
  input wire logic aclk,
  // Commands from the bench.
  input wire logic go,
  input wire logic [15:0] count,
  input wire logic slow,
  input wire logic fail,
  // Toward the channel.
  output dma_chan_pkg::xfer_in_t xfer_in
);
  import dma_chan_pkg::*;
  int k;
  // Idle data lines show the inverse of the last word, never a stale copy.
  initial begin
    xfer_in <= '0;
    forever begin
      @(posedge aclk);
      if (go) begin
        xfer_in.start <= 1'h1;
        xfer_in.count <= count;
        @(posedge aclk);
        xfer_in.start <= 1'h0;
        for (k = 0; k < count / 4; k++) begin
          if (slow) repeat (3) @(posedge aclk);
          xfer_in.beat <= !(fail && k == 1);
          xfer_in.err <= fail && k == 1;
          xfer_in.data <= 32'h5a00_0000 + k;
          @(posedge aclk);
          xfer_in.beat <= 1'h0;
          xfer_in.err <= 1'h0;
          xfer_in.data <= ~xfer_in.data;
          if (fail && k == 1) break;
          // One idle edge between beats keeps each beat a single-cycle pulse.
          @(posedge aclk);
        end
      end
    end
  end
endmodule : bus_slave_model

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import dma_chan_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, dat;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic go = 0, slow = 0, fail = 0;
  logic [15:0] count = 0;
  xfer_in_t xfer_in;
  xfer_out_t xfer_out;
  int n_fail = 0, tests_run = 0;
  always #20 aclk = ~aclk;
  dma_chan_irq i_dma_chan_irq (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .xfer_in(xfer_in), .xfer_out(xfer_out), .irq(irq));
  bus_slave_model i_bus_slave_model (.aclk(aclk), .go(go), .count(count), .slow(slow),
    .fail(fail), .xfer_in(xfer_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    int n;
    n = 0;
    b_ok = 0;
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    while (!b_ok && n < 50) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      n++;
      if (aw_ok) awvalid <= 1'h0;
      if (w_ok) wvalid <= 1'h0;
      if (b_ok) bready <= 1'h0;
    end
    if (!b_ok) n_fail++;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, ok;
    int n;
    n = 0;
    ok = 0;
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    while (!ok && n < 50) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      ok = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      n++;
      if (ar_ok) arvalid <= 1'h0;
      if (ok) rready <= 1'h0;
    end
    if (!ok) n_fail++;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, dat, resp);
    chk(dat, e);
    chk(32'(resp), 32'h0);
  endtask : rdc
  // Starts one transfer through the slave model and waits until the channel is idle again.
  task automatic run(input logic [15:0] c, input logic s, input logic f);
    logic ab;
    int n;
    ab = 0;
    n = 0;
    @(posedge aclk);
    go <= 1'h1;
    count <= c;
    slow <= s;
    fail <= f;
    @(posedge aclk);
    go <= 1'h0;
    while (xfer_out.busy !== 1'h1 && n < 20) begin
      @(negedge aclk);
      n++;
    end
    n = 0;
    while (xfer_out.busy !== 1'h0 && n < 200) begin
      @(negedge aclk);
      ab = ab | xfer_out.abort;
      n++;
    end
    @(negedge aclk);
    ab = ab | xfer_out.abort;
    chk(32'(xfer_out.busy), 32'h0);
    chk(32'(ab), 32'(f));
  endtask : run
  task automatic t_reset;
    rdc(8'h20, 32'h1);
    rdc(8'h24, 32'h0);
    rdc(8'h80, 32'h0);
    rdc(8'h00, 32'h0);
    wr(8'h80, 32'hffff_ffff, resp);
    rdc(8'h80, 32'h0);
    rd(8'h40, dat, resp);
    chk(32'(resp), 32'h2);
    chk(32'(irq), 32'h0);
  endtask : t_reset
  task automatic t_done;
    run(16'h0008, 1'h0, 1'h0);
    rdc(8'h24, 32'h2);
    rdc(8'h80, 32'h5a00_0001);
    chk(32'(irq), 32'h0);
    wr(8'h24, 32'h0, resp);
    rdc(8'h24, 32'h2);
    wr(8'h20, 32'h3, resp);
    chk(32'(resp), 32'h0);
    wstrb <= 4'he;
    @(negedge aclk);
    chk(32'(irq), 32'h1);
    wr(8'h20, 32'h0, resp);
    wstrb <= 4'hf;
    rdc(8'h20, 32'h3);
    wr(8'h24, 32'h2, resp);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
  endtask : t_done
  task automatic t_err;
    run(16'h0010, 1'h1, 1'h1);
    rdc(8'h24, 32'h1);
    rdc(8'h1c, 32'hc);
    chk(32'(irq), 32'h1);
    wr(8'h20, 32'h2, resp);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    wr(8'h00, 32'h1, resp);
    rdc(8'h1c, 32'h0);
    wr(8'h24, 32'h1, resp);
    rdc(8'h24, 32'h0);
    wr(8'h44, 32'h0, resp);
    chk(32'(resp), 32'h2);
  endtask : t_err
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_done();
    t_err();
    summarize();
  end
  initial begin
    #400000;
    n_fail++;
    summarize();
  end
endmodule : tb_top
